// ===== src/umf_dev_end.sv
`timescale 1ns/100ps
`default_nettype none
module umf_dev_end
	import umf_pkg::*;
(
	input wire logic pclk, // System clock
	input wire logic presetn, // Async reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB access phase
	input wire logic pwrite, // APB write
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	output logic irq, // Level interrupt
	umf_link_if.dev link // Serial link
);
	import umf_pkg::*;

	typedef struct packed {
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
		logic filt;
		logic dbl;
		logic txc_flag;
		logic tx_ninth;
		logic txen;
		logic rxen;
		logic [2:0] size;
		logic stop2;
		logic [11:0] baud;
		logic rxfull;
		logic [8:0] rxbuf;
		logic rxfe;
		logic [IRQ_W-1:0] irq_st;
		logic [IRQ_W-1:0] irq_mask;
		logic irq;
		logic go;
		logic [8:0] txd;
	} umf_dev_s;

	umf_dev_s st_reg, st_next;
	logic tx_busy, tx_done, rx_done, rx_type, rx_ferr, s2m;
	logic [8:0] rx_data;
	logic acc, done, wr, rd, store, drop;
	logic [31:0] rdv;
	logic mapped;

	umf_bit_engine umf_bit_engine_i (
		.pclk(pclk),
		.presetn(presetn),
		.baud_divisor(st_reg.baud),
		.double_speed(st_reg.dbl),
		.char_size(st_reg.size),
		.two_stop(st_reg.stop2),
		.rx_enable(st_reg.rxen),
		.tx_enable(st_reg.txen),
		.rx_line(link.m2s_line),
		.tx_start(st_reg.go),
		.tx_data(st_reg.txd),
		.tx_mark(1'b0),
		.tx_type(1'b0),
		.tx_line(s2m),
		.tx_busy(tx_busy),
		.tx_done(tx_done),
		.rx_done(rx_done),
		.rx_data(rx_data),
		.rx_type(rx_type),
		.rx_ferr(rx_ferr)
	);

	always_comb begin
		st_next = st_reg;
		st_next.go = 1'b0;
		acc = psel && penable;
		done = acc && st_reg.pready;
		wr = done && pwrite;
		rd = done && !pwrite;
		// A data frame under the filter never reaches the buffer or receive flags; it sets only IRQ_DROP
		drop = rx_done && st_reg.filt && !rx_type;
		store = rx_done && !drop;
		rdv = 32'h0000_0000;
		mapped = 1'b1;
		case (paddr)
			OFS_CTRL_STATUS_A: begin
				rdv[CA_FILTER] = st_reg.filt;
				rdv[CA_DOUBLE] = st_reg.dbl;
				rdv[CA_FERR] = st_reg.rxfe;
				rdv[CA_TXEMPTY] = !tx_busy && !st_reg.go;
				rdv[CA_TXC] = st_reg.txc_flag;
				rdv[CA_RXC] = st_reg.rxfull;
			end
			OFS_DATA_BUFFER: rdv[7:0] = st_reg.rxbuf[7:0];
			OFS_CTRL_B: begin
				rdv[CB_TX_NINTH] = st_reg.tx_ninth;
				rdv[CB_RX_NINTH] = st_reg.rxbuf[8];
				rdv[CB_TXEN] = st_reg.txen;
				rdv[CB_RXEN] = st_reg.rxen;
				rdv[CB_SIZE +: 3] = st_reg.size;
				rdv[CB_STOP2] = st_reg.stop2;
			end
			OFS_BAUD: rdv[11:0] = st_reg.baud;
			OFS_IRQ_STATUS: rdv[IRQ_W-1:0] = st_reg.irq_st;
			OFS_IRQ_MASK: rdv[IRQ_W-1:0] = st_reg.irq_mask;
			default: mapped = 1'b0;
		endcase
		// One wait state: answer registered the cycle after access starts
		if (acc && !st_reg.pready) begin
			st_next.pready = 1'b1;
			st_next.prdata = rdv;
			st_next.pslverr = !mapped;
		end else begin
			st_next.pready = 1'b0;
			st_next.prdata = 32'h0000_0000;
			st_next.pslverr = 1'b0;
		end
		if (wr) begin
			case (paddr)
				OFS_CTRL_STATUS_A: begin
					// Writing one to the tx flag clears it, so a
					// read-modify-write of the filter bit loses that flag
					st_next.filt = pwdata[CA_FILTER];
					st_next.dbl = pwdata[CA_DOUBLE];
					if (pwdata[CA_TXC]) begin
						st_next.txc_flag = 1'b0;
					end
				end
				OFS_DATA_BUFFER: begin
					// Write while a frame is pending is ignored
					if (!tx_busy && !st_reg.go) begin
						st_next.go = 1'b1;
						st_next.txd = {st_reg.tx_ninth, pwdata[7:0]};
					end
				end
				OFS_CTRL_B: begin
					st_next.tx_ninth = pwdata[CB_TX_NINTH];
					st_next.txen = pwdata[CB_TXEN];
					st_next.rxen = pwdata[CB_RXEN];
					st_next.size = pwdata[CB_SIZE +: 3];
					st_next.stop2 = pwdata[CB_STOP2];
					if (!pwdata[CB_RXEN]) begin
						st_next.rxfull = 1'b0;
						st_next.rxfe = 1'b0;
					end
				end
				OFS_BAUD: st_next.baud = pwdata[11:0];
				OFS_IRQ_STATUS: st_next.irq_st = st_reg.irq_st & ~pwdata[IRQ_W-1:0];
				OFS_IRQ_MASK: st_next.irq_mask = pwdata[IRQ_W-1:0];
				default: st_next.baud = st_reg.baud;
			endcase
		end
		if (rd && paddr == OFS_DATA_BUFFER) begin
			st_next.rxfull = 1'b0;
		end
		// Hardware sets come last so they win over a same-cycle clear
		if (store && st_reg.rxen) begin
			st_next.rxfull = 1'b1;
			st_next.rxbuf = rx_data;
			st_next.rxfe = rx_ferr;
			st_next.irq_st[IRQ_RX] = 1'b1;
		end
		if (drop) begin
			st_next.irq_st[IRQ_DROP] = 1'b1;
		end
		if (tx_done) begin
			st_next.txc_flag = 1'b1;
			st_next.irq_st[IRQ_TX] = 1'b1;
		end
		st_next.irq = |(st_next.irq_st & st_next.irq_mask);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
			st_reg.size <= SIZE_RST;
			st_reg.baud <= BAUD_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	assign prdata = st_reg.prdata;
	assign pready = st_reg.pready;
	assign pslverr = st_reg.pslverr;
	assign irq = st_reg.irq;
	assign link.s2m_line = s2m;
endmodule
`default_nettype wire

// ===== src/umf_pkg.sv
package umf_pkg;
	// Register byte offsets on the controller side
	localparam logic [7:0] OFS_CTRL_STATUS_A = 8'h00;
	localparam logic [7:0] OFS_DATA_BUFFER = 8'h04;
	localparam logic [7:0] OFS_CTRL_B = 8'h08;
	localparam logic [7:0] OFS_BAUD = 8'h0C;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
	// serial_ctrl_status_a fields
	localparam int CA_FILTER = 0;
	localparam int CA_DOUBLE = 1;
	localparam int CA_FERR = 4;
	localparam int CA_TXEMPTY = 5;
	localparam int CA_TXC = 6;
	localparam int CA_RXC = 7;
	// Control B fields
	localparam int CB_TX_NINTH = 0;
	localparam int CB_RX_NINTH = 1;
	localparam int CB_TXEN = 3;
	localparam int CB_RXEN = 4;
	localparam int CB_SIZE = 5;
	localparam int CB_STOP2 = 8;
	// Interrupt status and mask bits
	localparam int IRQ_RX = 0;
	localparam int IRQ_TX = 1;
	localparam int IRQ_DROP = 2;
	localparam int IRQ_W = 3;
	// Reset values and the nine-bit size code
	localparam logic [2:0] SIZE_RST = 3'h3;
	localparam logic [11:0] BAUD_RST = 12'h000;
	localparam logic [2:0] SIZE_NINE = 3'h7;
	// Oversampling and majority-vote sample numbers
	localparam logic [4:0] SPB_NORMAL = 5'h10;
	localparam logic [4:0] SPB_DOUBLE = 5'h08;
	localparam logic [4:0] VOTE_FIRST_N = 5'h08;
	localparam logic [4:0] VOTE_FIRST_D = 5'h04;
	localparam logic [4:0] VOTE_MID_N = 5'h09;
	localparam logic [4:0] VOTE_MID_D = 5'h05;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_START = 2'b01,
		ST_DATA = 2'b10,
		ST_STOP = 2'b11
	} umf_rx_state_e;

	// Data bit count for a character size code; codes 4..6 fall back to 8
	function automatic logic [3:0] umf_nbits(input logic [2:0] cs);
		case (cs)
			3'h0: umf_nbits = 4'h5;
			3'h1: umf_nbits = 4'h6;
			3'h2: umf_nbits = 4'h7;
			3'h7: umf_nbits = 4'h9;
			default: umf_nbits = 4'h8;
		endcase
	endfunction
endpackage

// ===== src/umf_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface umf_link_if;
	logic m2s_line; // Master transmit line, idle high
	logic s2m_line; // Device transmit line, idle high
	modport dev (input m2s_line, output s2m_line);
	modport mst (output m2s_line, input s2m_line);
endinterface
`default_nettype wire

// ===== src/umf_bit_engine.sv
`timescale 1ns/100ps
`default_nettype none
module umf_bit_engine
	import umf_pkg::*;
(
	input wire logic pclk, // System clock
	input wire logic presetn, // Async reset, active low
	input wire logic [11:0] baud_divisor, // Sample tick every divisor+1 clocks
	input wire logic double_speed, // 8 samples per bit instead of 16
	input wire logic [2:0] char_size, // Shared character size code
	input wire logic two_stop, // Send two stop bits
	input wire logic rx_enable, // Receiver on
	input wire logic tx_enable, // Transmitter on
	input wire logic rx_line, // Serial input
	input wire logic tx_start, // Pulse: send tx_data
	input wire logic [8:0] tx_data, // Character, bit 8 is the ninth bit
	input wire logic tx_mark, // Insert type bit after 5..8 data bits
	input wire logic tx_type, // Type bit value when tx_mark set
	output logic tx_line, // Serial output
	output logic tx_busy, // Frame in progress
	output logic tx_done, // Pulse at end of frame
	output logic rx_done, // Pulse: frame received
	output logic [8:0] rx_data, // Received character, upper bits zero
	output logic rx_type, // Frame-type bit
	output logic rx_ferr // First stop bit read as zero
);
	import umf_pkg::*;

	typedef struct packed {
		logic [11:0] div;
		umf_rx_state_e rxs;
		logic [4:0] rx_complete_flag;
		logic [3:0] rxn;
		logic [1:0] vote;
		logic [8:0] rsh;
		logic rprev;
		logic rdone;
		logic [8:0] rdata;
		logic rtype;
		logic rferr;
		logic tbusy;
		logic [4:0] tx_complete_flag;
		logic [3:0] txn;
		logic [11:0] tsh;
		logic tline;
		logic tdone;
	} umf_core_s;

	umf_core_s st_reg, st_next;
	logic tick, bitv;
	logic [3:0] nb;
	logic [4:0] spb, vf, vm;
	logic [11:0] frame;
	logic [3:0] flen;

	always_comb begin
		st_next = st_reg;
		tick = (st_reg.div == 12'h000);
		nb = umf_nbits(char_size);
		spb = double_speed ? SPB_DOUBLE : SPB_NORMAL;
		vf = double_speed ? VOTE_FIRST_D : VOTE_FIRST_N;
		vm = double_speed ? VOTE_MID_D : VOTE_MID_N;
		bitv = (st_reg.vote == 2'h2) || (st_reg.vote == 2'h1 && rx_line);
		frame = '1;
		frame[0] = 1'b0;
		for (int i = 0; i < 9; i++) begin
			if (4'(i) < nb) begin
				frame[i + 1] = tx_data[i];
			end
		end
		if (tx_mark && nb != 4'h9) begin
			frame[nb + 4'h1] = tx_type;
		end
		flen = nb + (two_stop ? 4'h3 : 4'h2);
		st_next.rdone = 1'b0;
		st_next.tdone = 1'b0;
		st_next.div = tick ? baud_divisor : st_reg.div - 12'h001;
		if (!rx_enable) begin
			st_next.rxs = ST_IDLE;
		end else if (tick) begin
			st_next.rprev = rx_line;
			if (st_reg.rxs == ST_IDLE) begin
				if (st_reg.rprev && !rx_line) begin
					st_next.rxs = ST_START;
					// The detecting tick is sample one, the next is two
					st_next.rx_complete_flag = 5'h02;
					st_next.vote = 2'h0;
				end
			end else begin
				st_next.rx_complete_flag = (st_reg.rx_complete_flag == spb) ? 5'h01 : st_reg.rx_complete_flag + 5'h01;
				if (st_reg.rx_complete_flag == vf || st_reg.rx_complete_flag == vm) begin
					st_next.vote = st_reg.vote + {1'b0, rx_line};
				end
				if (st_reg.rx_complete_flag == vm + 5'h01) begin
					st_next.vote = 2'h0;
					case (st_reg.rxs)
						ST_START: begin
							if (bitv) begin
								st_next.rxs = ST_IDLE;
							end
							st_next.rxn = 4'h0;
						end
						ST_DATA: begin
							st_next.rsh = {bitv, st_reg.rsh[8:1]};
							st_next.rxn = st_reg.rxn + 4'h1;
						end
						ST_STOP: begin
							// Only the first stop bit is used; next start may follow
							st_next.rxs = ST_IDLE;
							st_next.rdone = 1'b1;
							st_next.rdata = 9'(st_reg.rsh >> (4'h9 - nb));
							st_next.rferr = !bitv;
							st_next.rtype = (nb == 4'h9) ? st_reg.rsh[8] : bitv;
						end
						default: st_next.rxs = ST_IDLE;
					endcase
				end
				if (st_reg.rx_complete_flag == spb && st_reg.rxs == ST_START) begin
					st_next.rxs = ST_DATA;
				end
				if (st_reg.rx_complete_flag == spb && st_reg.rxs == ST_DATA && st_reg.rxn == nb) begin
					st_next.rxs = ST_STOP;
				end
			end
		end
		// Transmit path sees no filter input at all
		if (!st_reg.tbusy) begin
			st_next.tline = 1'b1;
			if (tx_start && tx_enable) begin
				st_next.tbusy = 1'b1;
				st_next.tx_complete_flag = 5'h01;
				st_next.tsh = frame;
				st_next.txn = flen;
				st_next.tline = frame[0];
			end
		end else if (tick) begin
			if (st_reg.tx_complete_flag == spb) begin
				st_next.tx_complete_flag = 5'h01;
				st_next.tsh = {1'b1, st_reg.tsh[11:1]};
				st_next.txn = st_reg.txn - 4'h1;
				st_next.tline = st_reg.tsh[1];
				if (st_reg.txn == 4'h1) begin
					st_next.tbusy = 1'b0;
					st_next.tdone = 1'b1;
					st_next.tline = 1'b1;
				end
			end else begin
				st_next.tx_complete_flag = st_reg.tx_complete_flag + 5'h01;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
			st_reg.rxs <= ST_IDLE;
			st_reg.rprev <= 1'b1;
			st_reg.tline <= 1'b1;
			st_reg.tsh <= 12'hFFF;
		end else begin
			st_reg <= st_next;
		end
	end

	assign tx_line = st_reg.tline;
	assign tx_busy = st_reg.tbusy;
	assign tx_done = st_reg.tdone;
	assign rx_done = st_reg.rdone;
	assign rx_data = st_reg.rdata;
	assign rx_type = st_reg.rtype;
	assign rx_ferr = st_reg.rferr;
endmodule
`default_nettype wire

// ===== src/umf_mst_end.sv
`timescale 1ns/100ps
`default_nettype none
module umf_mst_end
	import umf_pkg::*;
(
	input wire logic pclk, // System clock
	input wire logic presetn, // Async reset, active low
	input wire logic [11:0] baud_divisor, // Sample tick divisor
	input wire logic double_speed, // 8 samples per bit
	input wire logic [2:0] char_size, // Character size code
	input wire logic send_valid, // Request to send one frame
	input wire logic send_addr, // Frame is an address frame
	input wire logic [7:0] send_data, // Frame payload
	output logic send_ready, // Request accepted when high with valid
	output logic reply_valid, // Pulse: frame received from device
	output logic [8:0] reply_data, // Received character
	umf_link_if.mst link // Serial link
);
	import umf_pkg::*;

	typedef struct packed {
		logic ready;
		logic go;
		logic [8:0] txd;
		logic typ;
		logic rv;
		logic [8:0] rd;
	} umf_mst_s;

	umf_mst_s st_reg, st_next;
	logic tx_busy, rx_done, m2s;
	logic [8:0] rx_data;

	umf_bit_engine umf_bit_engine_i (
		.pclk(pclk),
		.presetn(presetn),
		.baud_divisor(baud_divisor),
		.double_speed(double_speed),
		.char_size(char_size),
		.two_stop(char_size != SIZE_NINE),
		.rx_enable(1'b1),
		.tx_enable(1'b1),
		.rx_line(link.s2m_line),
		.tx_start(st_reg.go),
		.tx_data(st_reg.txd),
		.tx_mark(1'b1),
		.tx_type(st_reg.typ),
		.tx_line(m2s),
		.tx_busy(tx_busy),
		.tx_done(),
		.rx_done(rx_done),
		.rx_data(rx_data),
		.rx_type(),
		.rx_ferr()
	);

	always_comb begin
		st_next = st_reg;
		st_next.go = 1'b0;
		st_next.rv = rx_done;
		if (rx_done) begin
			st_next.rd = rx_data;
		end
		if (st_reg.ready && send_valid) begin
			st_next.ready = 1'b0;
			st_next.go = 1'b1;
			st_next.txd = {send_addr, send_data};
			st_next.typ = send_addr;
		end else if (!st_reg.ready && !st_reg.go && !tx_busy) begin
			st_next.ready = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign send_ready = st_reg.ready;
	assign reply_valid = st_reg.rv;
	assign reply_data = st_reg.rd;
	assign link.m2s_line = m2s;
endmodule
`default_nettype wire

// ===== tb/umf_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module umf_assertions (
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset
	input wire logic m2s_line, // Master line
	input wire logic s2m_line, // Device line
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pready, // APB ready
	input wire logic pslverr, // APB error
	input wire logic [31:0] prdata, // APB data
	input wire logic send_valid, // Send request
	input wire logic send_ready, // Send accept
	input wire logic reply_valid // Reply pulse
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	ready_one_wait_a: assert property (psel && penable && !pready |=> pready)
		else $error("pready not one cycle after access");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	err_with_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
		else $error("prdata not zero outside answer");
	take_drops_ready_a: assert property (send_valid && send_ready |=> !send_ready)
		else $error("send_ready stays high after take");
	start_follows_a: assert property
		(send_valid && send_ready |-> ##[2:3] $fell(m2s_line))
		else $error("start bit not two edges after take");
	mst_start_len_a: assert property ($fell(m2s_line) |-> !m2s_line [*8])
		else $error("master start bit too short");
	dev_start_len_a: assert property ($fell(s2m_line) |-> !s2m_line [*8])
		else $error("device start bit too short");
	reply_pulse_a: assert property (reply_valid |=> !reply_valid)
		else $error("reply_valid longer than one cycle");
	cover property (pslverr);
	cover property ($fell(s2m_line));
	cover property (reply_valid);
endmodule
`default_nettype wire

// ===== tb/uart_rx_multiproc_filter_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module uart_rx_multiproc_filter_tb_top;
	import umf_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, nine;
	logic [7:0] paddr, send_data;
	logic [31:0] pwdata, prdata;
	logic [11:0] baud_divisor;
	logic double_speed, send_valid, send_addr, send_ready, reply_valid;
	logic [2:0] char_size;
	logic [8:0] reply_data;
	int err_count, num_checks;
	umf_link_if umf_link_if_i();
	umf_dev_end umf_dev_end_i(.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.link(umf_link_if_i));
	umf_mst_end umf_mst_end_i(.pclk(pclk), .presetn(presetn),
		.baud_divisor(baud_divisor), .double_speed(double_speed),
		.char_size(char_size), .send_valid(send_valid), .send_addr(send_addr),
		.send_data(send_data), .send_ready(send_ready),
		.reply_valid(reply_valid), .reply_data(reply_data),
		.link(umf_link_if_i));
	umf_assertions umf_assertions_i(.pclk(pclk), .presetn(presetn),
		.m2s_line(umf_link_if_i.m2s_line), .s2m_line(umf_link_if_i.s2m_line),
		.psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
		.prdata(prdata), .send_valid(send_valid), .send_ready(send_ready),
		.reply_valid(reply_valid));
	task automatic end_of_test;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		num_checks++;
		if (g !== x) begin
			err_count++;
			$display("wrong value at %0t got %h expected %h", $time, g, x);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] x);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r & m, x);
	endtask
	task automatic wait_irq;
		int n;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (irq !== 1'b1 && n < 5000);
		chk({31'h0, irq}, 32'h1);
	endtask
	task automatic send(input logic a, input logic [7:0] d);
		@(posedge pclk);
		send_addr <= a;
		send_data <= d;
		send_valid <= 1'b1;
		do @(posedge pclk); while (send_ready !== 1'b1);
		send_valid <= 1'b0;
	endtask
	// Both ends get the same size and speed; the device also gets its filter, receiver and transmitter switched on
	task automatic cfg(input logic [2:0] cs, input logic dbl);
		char_size <= cs;
		double_speed <= dbl;
		wr(OFS_CTRL_B, {24'h0, cs, 5'h18});
		wr(OFS_CTRL_STATUS_A, {30'h0, dbl, 1'b1});
		nine = (cs == SIZE_NINE);
	endtask
	task automatic xfer(input logic a, input logic [7:0] d, input logic [8:0] x,
		input logic kept);
		wr(OFS_IRQ_STATUS, 32'h7);
		send(a, d);
		wait_irq();
		rd(OFS_IRQ_STATUS, 32'h7, kept ? 32'h1 : 32'h4);
		rd(OFS_CTRL_STATUS_A, 32'h90, {24'h0, kept, 7'h0});
		if (kept) begin
			if (nine)
				rd(OFS_CTRL_B, 32'h2, {30'h0, x[8], 1'b0});
			rd(OFS_DATA_BUFFER, 32'hFF, {24'h0, x[7:0]});
		end
	endtask
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	// About three times the expected run
	initial begin
		#80000;
		err_count++;
		end_of_test();
	end
	initial begin
		int n;
		logic [31:0] r;
		logic e;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		baud_divisor = 12'h001;
		double_speed = 1'b0;
		char_size = SIZE_RST;
		send_valid = 1'b0;
		send_addr = 1'b0;
		send_data = 8'h00;
		nine = 1'b0;
		err_count = 0;
		num_checks = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rd(OFS_CTRL_B, 32'hFFFFFFFF, {24'h0, SIZE_RST, 5'h0});
		rd(OFS_BAUD, 32'hFFFFFFFF, 32'h0);
		apb(1'b0, 8'h18, 32'h0, r, e);
		chk(r, 32'h0);
		chk({31'h0, e}, 32'h1);
		wr(OFS_BAUD, 32'h1);
		wr(OFS_IRQ_MASK, 32'h7);
		cfg(SIZE_NINE, 1'b0);
		xfer(1'b0, 8'h11, 9'h000, 1'b0);
		wr(OFS_IRQ_MASK, 32'h0);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, 32'h0);
		wr(OFS_IRQ_MASK, 32'h7);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, 32'h1);
		wr(OFS_IRQ_STATUS, 32'h7);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, 32'h0);
		xfer(1'b1, 8'h5A, 9'h15A, 1'b1);
		wr(OFS_CTRL_STATUS_A, 32'h0);
		xfer(1'b0, 8'h33, 9'h033, 1'b1);
		wr(OFS_CTRL_STATUS_A, 32'h1);
		xfer(1'b0, 8'h44, 9'h000, 1'b0);
		wr(OFS_IRQ_STATUS, 32'h7);
		wr(OFS_CTRL_B, 32'h000001F9);
		wr(OFS_DATA_BUFFER, 32'h3C);
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (reply_valid !== 1'b1 && n < 5000);
		chk({23'h0, reply_data}, 32'h13C);
		wait_irq();
		rd(OFS_IRQ_STATUS, 32'h7, 32'h2);
		rd(OFS_CTRL_STATUS_A, 32'h63, 32'h61);
		wr(OFS_CTRL_STATUS_A, 32'h1);
		rd(OFS_CTRL_STATUS_A, 32'h41, 32'h41);
		wr(OFS_CTRL_STATUS_A, 32'h41);
		rd(OFS_CTRL_STATUS_A, 32'h41, 32'h01);
		for (int c = 0; c < 4; c++) begin
			cfg(c[2:0], 1'b0);
			xfer(1'b0, 8'hA5, 9'h000, 1'b0);
			xfer(1'b1, 8'hA5, {1'b0, 8'hA5 & (8'hFF >> (3 - c))}, 1'b1);
		end
		cfg(SIZE_NINE, 1'b1);
		xfer(1'b1, 8'hC3, 9'h1C3, 1'b1);
		xfer(1'b0, 8'hC3, 9'h000, 1'b0);
		end_of_test();
	end
endmodule
`default_nettype wire
